// >>> clock_tree_pkg.sv
package clock_tree_pkg;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    localparam logic [3:0] REG_PLL_CTRL   = 4'h0;
    localparam logic [3:0] REG_PLL_MULT   = 4'h1;
    localparam logic [3:0] REG_PLL_DIV    = 4'h2;
    localparam logic [3:0] REG_PLL_STAT   = 4'h3;
    localparam logic [3:0] REG_IMO_CTRL   = 4'h4;
    localparam logic [3:0] REG_IMO_STAT   = 4'h5;
    localparam logic [3:0] REG_MST_CTRL   = 4'h6;
    localparam logic [3:0] REG_BUS_DIV    = 4'h7;
    localparam logic [3:0] REG_CPU_DIV    = 4'h8;
    localparam logic [3:0] REG_USB_SRC    = 4'h9;
    localparam logic [3:0] REG_LSO_CTRL   = 4'ha;
    localparam logic [3:0] REG_IMO_KHZ    = 4'hb;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PLL_EN_BIT    = 0;
    localparam int PLL_WAIT_BIT  = 1;
    localparam int PLL_REF_LSB   = 2;
    localparam int PLL_PUMP_LSB  = 4;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_TOUT_BIT = 2;
    localparam int STAT_OK_BIT   = 3;
    localparam int STAT_USE_BIT  = 4;
    localparam int IMO_EN_BIT    = 0;
    localparam int IMO_WAIT_BIT  = 1;
    localparam int IMO_SRC_LSB   = 2;
    localparam int IMO_DBL_BIT   = 4;
    localparam int IMO_FREQ_LSB  = 8;
    localparam int IMO_SETL_BIT  = 0;
    localparam int IMO_BUSY_BIT  = 1;
    localparam int IMO_USBL_BIT  = 2;
    localparam int MST_SRC_LSB   = 0;
    localparam int MST_DIV_LSB   = 8;
    localparam int LSO_1K_BIT    = 0;
    localparam int LSO_100K_BIT  = 1;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PLL_MULT_RST = 8'h04;
    localparam logic [4:0] PLL_DIV_RST  = 5'h01;
    localparam logic [2:0] PLL_PUMP_RST = 3'h2;
    localparam logic [3:0] IMO_FREQ_RST = 4'h3;
    localparam logic       LSO_1K_RST   = 1'b1;
    localparam logic       LSO_100K_RST = 1'b0;

    // ----------------------------------------------------------------
    // Selector codes
    // ----------------------------------------------------------------
    localparam logic [1:0] REF_IMO      = 2'h0;
    localparam logic [1:0] REF_XTAL     = 2'h1;
    localparam logic [1:0] REF_DSI      = 2'h2;
    localparam logic [1:0] MST_IMO      = 2'h0;
    localparam logic [1:0] MST_PLL      = 2'h1;
    localparam logic [1:0] MST_XTAL     = 2'h2;
    localparam logic [1:0] MST_DSI      = 2'h3;
    localparam logic [1:0] USB_IMO2X    = 2'h0;
    localparam logic [1:0] USB_IMO      = 2'h1;
    localparam logic [1:0] USB_PLL      = 2'h2;
    localparam logic [1:0] USB_DSI      = 2'h3;

    localparam logic [3:0] FREQ_3M      = 4'h0;
    localparam logic [3:0] FREQ_6M      = 4'h1;
    localparam logic [3:0] FREQ_12M     = 4'h2;
    localparam logic [3:0] FREQ_24M     = 4'h3;
    localparam logic [3:0] FREQ_48M     = 4'h4;
    localparam logic [3:0] FREQ_62M     = 4'h5;
    localparam logic [3:0] FREQ_74M     = 4'h6;
    localparam logic [3:0] usb_trimmed_frequency_setting = 4'h8;

    localparam logic [16:0] KHZ_3M      = 17'h00bb8;
    localparam logic [16:0] KHZ_6M      = 17'h01770;
    localparam logic [16:0] KHZ_12M     = 17'h02ee0;
    localparam logic [16:0] KHZ_24M     = 17'h05dc0;
    localparam logic [16:0] KHZ_48M     = 17'h0bb80;
    localparam logic [16:0] KHZ_62M     = 17'h0f488;
    localparam logic [16:0] KHZ_74M     = 17'h123cc;

    // Tick vector positions of the synchronised sources
    localparam int TICK_IMO  = 0;
    localparam int TICK_XTAL = 1;
    localparam int TICK_DSI  = 2;
    localparam int TICK_PLL  = 3;
    localparam int LOCK_IDX  = 4;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_KHZ    = 40000;
    localparam int PLL_LOCK_WAIT_US = 250;
    localparam int IMO_SETTLE_US   = 6;
    localparam int PLL_LOCK_WAIT_CYC = (PLL_LOCK_WAIT_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam int IMO_SETTLE_CYC  = (IMO_SETTLE_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam logic [15:0] IMO_SETTLE_LAST = 16'(IMO_SETTLE_CYC - 1);

    typedef enum logic [0:0] {W_IDLE, W_RUN} wait_state_t;

endpackage

// >>> tick_divider.sv
`timescale 1ns/1ps
module tick_divider
    import clock_tree_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        tickIn,
    input  wire logic [15:0] divisor,
    output logic             tickOut
);

    typedef struct packed {
        logic [15:0] count;
        logic        out;
    } div_state_t;

    div_state_t s_q;
    div_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.out = 1'b0;
        if (tickIn) begin
            // on mclk edges
            // Output edges only ever fall on mclk edges gated by the source tick
            // no runt pulses
            // Comparing with >= lets a shrunk divisor wrap at once instead of
            // running to 65535, and a grown one just extends the current period
            if (s_q.count >= divisor) begin
                s_d.count = 16'h0000;
                s_d.out   = 1'b1;
            end else begin
                s_d.count = s_q.count + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign tickOut = s_q.out;

endmodule

// >>> clock_tree_control.sv
// Operation
// - Missing lock reports timeout, yet loop clock becomes usable afterwards.
// - Loop output equals reference times multiplier over divisor.
// - Loop reference code 0 main oscillator, 1 crystal, 2 interconnect input.
// - Frequency code 0-6 decodes 3 to 74.7 MHz, 8 USB-trimmed 24 MHz.
// - Frequency changes while running; USB setting alone enables USB locking.
// - Oscillator block output defaults to oscillator, else crystal or interconnect.
// - Doubler gives only one midpoint pulse per input period, at its input frequency; disabled it gives nothing.
// - Master selector 0 oscillator, 1 loop, 2 crystal, 3 interconnect.
// - Master clock is source divided by 8-bit value plus one.
// - Bus clock is its input divided by 16-bit value plus one.
// - CPU clock is its input divided by 4-bit value plus one.
// - USB selector 0 doubler midpoint pulses, 1 oscillator, 2 loop, 3 interconnect.
// - 1 kHz low-speed output on after reset; both outputs separately switchable.
// - Derived clock edges fall only on rising system clock edges.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module clock_tree_control
    import clock_tree_pkg::*;
#(
    parameter int unsigned LOCK_WAIT_CYCLES = PLL_LOCK_WAIT_CYC
) (
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [DATA_W-1:0] regRdata,
    input  wire logic              imoClkIn,
    input  wire logic              xtalClkIn,
    input  wire logic              dsiClkIn,
    input  wire logic              pllClkIn,
    input  wire logic              pllLockIn,
    output logic                   pllEnable,
    output logic      [1:0]        pllRefSel,
    output logic      [7:0]        pllMult,
    output logic      [4:0]        pllDiv,
    output logic      [2:0]        pllPump,
    output logic                   imoEnable,
    output logic      [3:0]        imoFreqCode,
    output logic                   usbLockEnable,
    output logic                   pllLocked,
    output logic                   imoOutTick,
    output logic                   usbTick,
    output logic                   masterTick,
    output logic                   busTick,
    output logic                   cpuTick,
    output logic                   lso1kEnable,
    output logic                   lso100kEnable
);

    localparam logic [15:0] LOCK_LAST = 16'(LOCK_WAIT_CYCLES - 1);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic pickTick(input logic [1:0] sel, input logic [3:0] srcVec);
        pickTick = srcVec[sel];
    endfunction

    function automatic logic [16:0] freqKhz(input logic [3:0] code);
        case (code)
            FREQ_3M:                       freqKhz = KHZ_3M;
            FREQ_6M:                       freqKhz = KHZ_6M;
            FREQ_12M:                      freqKhz = KHZ_12M;
            FREQ_24M:                      freqKhz = KHZ_24M;
            FREQ_48M:                      freqKhz = KHZ_48M;
            FREQ_62M:                      freqKhz = KHZ_62M;
            FREQ_74M:                      freqKhz = KHZ_74M;
            usb_trimmed_frequency_setting: freqKhz = KHZ_24M;
            default:                       freqKhz = 17'h00000;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0]  syncA;
        logic [4:0]  syncB;
        logic [3:0]  prevLvl;
        logic        pllEn;
        logic        pllWait;
        logic [1:0]  pllRef;
        logic [2:0]  pllPump;
        logic [7:0]  pllMult;
        logic [4:0]  pllDiv;
        wait_state_t pllState;
        logic [15:0] pllCnt;
        logic        pllLocked;
        logic        pllBusy;
        logic        pllOk;
        logic        pllTimeout;
        logic        pllUsable;
        logic        imoEn;
        logic        imoWait;
        logic [1:0]  imoSrc;
        logic        imoDbl;
        logic [3:0]  imoFreq;
        logic        usbLockEn;
        wait_state_t imoState;
        logic [15:0] imoCnt;
        logic        imoSettled;
        logic [1:0]  mstSrc;
        logic [7:0]  mstDiv;
        logic [15:0] busDiv;
        logic [3:0]  cpuDiv;
        logic [1:0]  usbSrc;
        logic        lso1k;
        logic        lso100k;
        logic        imoOutTick;
        logic        usbTick;
        logic [15:0] sinceTick;
        logic [15:0] lastPeriod;
        logic [31:0] rdata;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;

    logic [3:0] tickPulse;
    logic       imoBlkTick;
    logic       dblTick;
    logic       pllTickOk;
    logic       mstSrcTick;
    logic [15:0] halfPeriod;

    // ----------------------------------------------------------------
    // Source ticks
    // ----------------------------------------------------------------
    // Rising edge of each synchronised source becomes one mclk-wide pulse
    assign tickPulse  = s_q.syncB[3:0] & ~s_q.prevLvl;
    assign pllTickOk  = tickPulse[TICK_PLL] & s_q.pllUsable;
    assign imoBlkTick = pickTick(s_q.imoSrc,
                                 {1'b0, tickPulse[TICK_DSI], tickPulse[TICK_XTAL],
                                  tickPulse[TICK_IMO] & s_q.imoEn});
    // doubler midpoint pulse
    // Midpoint is estimated from the previous period, so the first period after
    // reset carries no extra pulse; a source faster than mclk/2 cannot double
    assign halfPeriod = {1'b0, s_q.lastPeriod[15:1]};
    assign dblTick    = s_q.imoDbl & ~imoBlkTick & (halfPeriod != 16'h0000)
                        & (s_q.sinceTick + 16'h0001 == halfPeriod);
    // glitch-free select
    // Sources are single-cycle pulses, so a switch between them can only drop or
    // keep whole pulses, never cut one short
    assign mstSrcTick = pickTick(s_q.mstSrc,
                                 {tickPulse[TICK_DSI], tickPulse[TICK_XTAL], pllTickOk, imoBlkTick});

    always_comb begin
        s_d = s_q;
        s_d.syncA   = {pllLockIn, pllClkIn, dsiClkIn, xtalClkIn, imoClkIn};
        s_d.syncB   = s_q.syncA;
        s_d.prevLvl = s_q.syncB[3:0];
        s_d.rdata   = 32'h00000000;

        s_d.pllLocked = s_q.pllEn & s_q.syncB[LOCK_IDX];

        if (s_q.pllState == W_RUN) begin
            if (s_q.syncB[LOCK_IDX]) begin
                s_d.pllState = W_IDLE;
                s_d.pllBusy  = 1'b0;
                s_d.pllOk    = 1'b1;
            end else if (s_q.pllCnt == LOCK_LAST) begin
                s_d.pllState   = W_IDLE;
                s_d.pllBusy    = 1'b0;
                s_d.pllTimeout = 1'b1;
            end else begin
                s_d.pllCnt = s_q.pllCnt + 16'h0001;
            end
        end

        if (s_q.imoState == W_RUN) begin
            if (s_q.imoCnt == IMO_SETTLE_LAST) begin
                s_d.imoState   = W_IDLE;
                s_d.imoSettled = 1'b1;
            end else begin
                s_d.imoCnt = s_q.imoCnt + 16'h0001;
            end
        end

        // Period tracking for the doubler
        if (imoBlkTick) begin
            s_d.lastPeriod = s_q.sinceTick + 16'h0001;
            s_d.sinceTick  = 16'h0000;
        end else if (s_q.sinceTick != 16'hffff) begin
            s_d.sinceTick = s_q.sinceTick + 16'h0001;
        end
        s_d.imoOutTick = imoBlkTick;
        s_d.usbTick = pickTick(s_q.usbSrc, {tickPulse[TICK_DSI], pllTickOk, imoBlkTick, dblTick});

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (regWr) begin
            case (regAddr)
                REG_PLL_CTRL: begin
                    s_d.pllWait = regWdata[PLL_WAIT_BIT];
                    s_d.pllRef  = regWdata[PLL_REF_LSB +: 2];
                    s_d.pllPump = regWdata[PLL_PUMP_LSB +: 3];
                    s_d.pllEn   = regWdata[PLL_EN_BIT];
                    if (!regWdata[PLL_EN_BIT]) begin
                        s_d.pllLocked = 1'b0;
                        s_d.pllState  = W_IDLE;
                        s_d.pllBusy   = 1'b0;
                    end else if (!s_q.pllEn) begin
                        s_d.pllOk      = 1'b0;
                        s_d.pllTimeout = 1'b0;
                        s_d.pllCnt     = 16'h0000;
                        s_d.pllState   = regWdata[PLL_WAIT_BIT] ? W_RUN : W_IDLE;
                        s_d.pllBusy    = regWdata[PLL_WAIT_BIT];
                    end
                end
                REG_PLL_MULT: s_d.pllMult = regWdata[7:0];
                REG_PLL_DIV:  s_d.pllDiv  = regWdata[4:0];
                REG_IMO_CTRL: begin
                    s_d.imoWait = regWdata[IMO_WAIT_BIT];
                    s_d.imoSrc  = regWdata[IMO_SRC_LSB +: 2];
                    s_d.imoDbl  = regWdata[IMO_DBL_BIT];
                    s_d.imoFreq = regWdata[IMO_FREQ_LSB +: 4];
                    s_d.imoEn   = regWdata[IMO_EN_BIT];
                    if (!regWdata[IMO_EN_BIT]) begin
                        s_d.imoState   = W_IDLE;
                        s_d.imoSettled = 1'b0;
                    end else if (!s_q.imoEn) begin
                        s_d.imoCnt     = 16'h0000;
                        s_d.imoState   = regWdata[IMO_WAIT_BIT] ? W_RUN : W_IDLE;
                        s_d.imoSettled = ~regWdata[IMO_WAIT_BIT];
                    end
                end
                REG_MST_CTRL: begin
                    s_d.mstSrc = regWdata[MST_SRC_LSB +: 2];
                    s_d.mstDiv = regWdata[MST_DIV_LSB +: 8];
                end
                REG_BUS_DIV:  s_d.busDiv = regWdata[15:0];
                REG_CPU_DIV:  s_d.cpuDiv = regWdata[3:0];
                REG_USB_SRC:  s_d.usbSrc = regWdata[1:0];
                REG_LSO_CTRL: begin
                    s_d.lso1k   = regWdata[LSO_1K_BIT];
                    s_d.lso100k = regWdata[LSO_100K_BIT];
                end
                default: begin
                end
            endcase
        end

        s_d.usbLockEn = (s_d.imoFreq == usb_trimmed_frequency_setting);
        s_d.pllUsable = s_d.pllEn & (s_d.pllState == W_IDLE);

        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        if (regRd) begin
            case (regAddr)
                REG_PLL_CTRL: s_d.rdata = {25'h0000000, s_q.pllPump, s_q.pllRef, s_q.pllWait, s_q.pllEn};
                REG_PLL_MULT: s_d.rdata = {24'h000000, s_q.pllMult};
                REG_PLL_DIV:  s_d.rdata = {27'h0000000, s_q.pllDiv};
                REG_PLL_STAT: s_d.rdata = {27'h0000000, s_q.pllUsable, s_q.pllOk, s_q.pllTimeout,
                                           s_q.pllBusy, s_q.pllLocked};
                REG_IMO_CTRL: s_d.rdata = {20'h00000, s_q.imoFreq, 3'h0, s_q.imoDbl, s_q.imoSrc,
                                           s_q.imoWait, s_q.imoEn};
                REG_IMO_STAT: s_d.rdata = {29'h00000000, s_q.usbLockEn, s_q.imoState == W_RUN,
                                           s_q.imoSettled};
                REG_MST_CTRL: s_d.rdata = {16'h0000, s_q.mstDiv, 6'h00, s_q.mstSrc};
                REG_BUS_DIV:  s_d.rdata = {16'h0000, s_q.busDiv};
                REG_CPU_DIV:  s_d.rdata = {28'h0000000, s_q.cpuDiv};
                REG_USB_SRC:  s_d.rdata = {30'h00000000, s_q.usbSrc};
                REG_LSO_CTRL: s_d.rdata = {30'h00000000, s_q.lso100k, s_q.lso1k};
                REG_IMO_KHZ:  s_d.rdata = {15'h0000, freqKhz(s_q.imoFreq)};
                default:      s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q          <= '0;
            s_q.pllMult  <= PLL_MULT_RST;
            s_q.pllDiv   <= PLL_DIV_RST;
            s_q.pllPump  <= PLL_PUMP_RST;
            s_q.imoFreq  <= IMO_FREQ_RST;
            s_q.lso1k    <= LSO_1K_RST;
            s_q.lso100k  <= LSO_100K_RST;
            s_q.pllState <= W_IDLE;
            s_q.imoState <= W_IDLE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Dividers
    // ----------------------------------------------------------------
    // master divide by n+1
    tick_divider u_mst (
        .mclk    (mclk),
        .srst    (srst),
        .ce      (ce),
        .tickIn  (mstSrcTick),
        .divisor ({8'h00, s_q.mstDiv}),
        .tickOut (masterTick)
    );

    tick_divider u_bus (
        .mclk    (mclk),
        .srst    (srst),
        .ce      (ce),
        .tickIn  (masterTick),
        .divisor (s_q.busDiv),
        .tickOut (busTick)
    );

    tick_divider u_cpu (
        .mclk    (mclk),
        .srst    (srst),
        .ce      (ce),
        .tickIn  (masterTick),
        .divisor ({12'h000, s_q.cpuDiv}),
        .tickOut (cpuTick)
    );

    assign regRdata      = s_q.rdata;
    assign pllEnable     = s_q.pllEn;
    assign pllRefSel     = s_q.pllRef;
    assign pllMult       = s_q.pllMult;
    assign pllDiv        = s_q.pllDiv;
    assign pllPump       = s_q.pllPump;
    assign imoEnable     = s_q.imoEn;
    assign imoFreqCode   = s_q.imoFreq;
    assign usbLockEnable = s_q.usbLockEn;
    assign pllLocked     = s_q.pllLocked;
    assign imoOutTick    = s_q.imoOutTick;
    assign usbTick       = s_q.usbTick;
    assign lso1kEnable   = s_q.lso1k;
    assign lso100kEnable = s_q.lso100k;

endmodule

// >>> clock_tree_props.sv
`timescale 1ns/1ps
module clock_tree_props
    import clock_tree_pkg::*;
#(
    parameter int unsigned LOCK_WAIT_CYCLES = PLL_LOCK_WAIT_CYC
) (
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    input  wire logic [DATA_W-1:0] regRdata,
    input  wire logic              pllEnable,
    input  wire logic              pllLocked,
    input  wire logic [7:0]        pllMult,
    input  wire logic [3:0]        imoFreqCode,
    input  wire logic              usbLockEnable,
    input  wire logic              masterTick,
    input  wire logic              lso1kEnable
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_wr(logic [3:0] a);
        regWr && regAddr == a;
    endsequence
    chk_en_write: assert property (s_wr(REG_PLL_CTRL) |=> pllEnable == $past(regWdata[PLL_EN_BIT]))
        else $error("loop enable does not follow write");
    chk_mult_write: assert property (s_wr(REG_PLL_MULT) |=> pllMult == $past(regWdata[7:0]))
        else $error("multiplier does not follow write");
    chk_freq_write: assert property (s_wr(REG_IMO_CTRL) |=> imoFreqCode == $past(regWdata[11:8]))
        else $error("frequency code does not follow write");
    chk_lso_write: assert property (s_wr(REG_LSO_CTRL) |=> lso1kEnable == $past(regWdata[LSO_1K_BIT]))
        else $error("low speed enable does not follow write");
    chk_usb_lock: assert property ($stable(imoFreqCode) |-> usbLockEnable == (imoFreqCode == 4'h8))
        else $error("usb locking enable wrong for frequency code");
    chk_lock_off: assert property (!pllEnable [*2] |-> !pllLocked)
        else $error("lock seen while loop disabled");
    chk_lock_read: assert property (regRd && regAddr == REG_PLL_STAT |=> regRdata[0] == $past(pllLocked))
        else $error("status lock bit differs from lock output");
    chk_khz_read: assert property (regRd && regAddr == REG_IMO_KHZ && imoFreqCode == FREQ_48M |=> regRdata == 32'h0bb80)
        else $error("frequency readback wrong");
    chk_tick_single: assert property (masterTick |=> !masterTick)
        else $error("master tick longer than one cycle");
endmodule
bind clock_tree_control clock_tree_props #(.LOCK_WAIT_CYCLES(LOCK_WAIT_CYCLES)) i_props (
    .mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .pllEnable(pllEnable), .pllLocked(pllLocked), .pllMult(pllMult),
    .imoFreqCode(imoFreqCode), .usbLockEnable(usbLockEnable), .masterTick(masterTick), .lso1kEnable(lso1kEnable));

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    import clock_tree_pkg::*;
    localparam int unsigned LW = 20;
    logic              mclk, srst, regWr, regRd, pllLockIn;
    logic              rdSeen = 1'b0;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata, seed;
    logic [DATA_W-1:0] expQ[$];
    logic [7:0]        srcCnt = 8'h00;
    logic [16:0]       khz[8] = '{KHZ_3M, KHZ_6M, KHZ_12M, KHZ_24M, KHZ_48M, KHZ_62M, KHZ_74M, KHZ_24M};
    logic [2:0]        ticks;
    int                bad_count = 0;
    int                compares = 0;
    clock_tree_control #(.LOCK_WAIT_CYCLES(LW)) i_dut (
        .mclk(mclk), .srst(srst), .ce(1'b1), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .imoClkIn(srcCnt[2]), .xtalClkIn(srcCnt[3]), .dsiClkIn(srcCnt[4]),
        .pllClkIn(srcCnt[2]), .pllLockIn(pllLockIn), .pllEnable(), .pllRefSel(), .pllMult(), .pllDiv(),
        .pllPump(), .imoEnable(), .imoFreqCode(), .usbLockEnable(), .pllLocked(), .imoOutTick(), .usbTick(),
        .masterTick(ticks[0]), .busTick(ticks[1]), .cpuTick(ticks[2]), .lso1kEnable(), .lso100kEnable());
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        {regWr, regAddr, regWdata} <= {1'b1, a, d};
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [DATA_W-1:0] e);
        expQ.push_back(e);
        @(posedge mclk);
        {regRd, regAddr} <= {1'b1, a};
        @(posedge mclk);
        regRd <= 1'b0;
    endtask
    // Second interval only: the first may be cut by the divider change
    task automatic gap(input int s, input int e);
        int n;
        repeat (2) begin
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (!ticks[s] && n < 600);
        end
        chk(32'(n), 32'(e));
        if (n >= 600) tally_and_finish();
    endtask
    // ----------------------------------------------------------------
    // Stimulus and read checking
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) srcCnt <= srcCnt + 8'h01;
    always @(posedge mclk) begin
        rdSeen <= regRd;
        if (rdSeen) chk(regRdata, expQ.pop_front());
    end
    initial begin
        {srst, regWr, regRd, pllLockIn} = 4'b1000;
        {regAddr, regWdata} = '0;
        seed = 32'h40db18c8;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        rd(REG_PLL_MULT, 32'h4);
        rd(REG_IMO_CTRL, 32'h300);
        rd(REG_LSO_CTRL, 32'h1);
        wr(4'hf, seed);
        rd(4'hf, 32'h0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(REG_IMO_CTRL, {20'h0, (i < 7) ? 4'(i) : usb_trimmed_frequency_setting, 8'h00});
            wr(REG_IMO_KHZ, seed);
            rd(REG_IMO_KHZ, 32'(khz[i]));
        end
        wr(REG_PLL_MULT, {24'h0, seed[7:0] | 8'h04});
        rd(REG_PLL_MULT, {24'h0, seed[7:0] | 8'h04});
        wr(REG_PLL_CTRL, 32'h23);
        rd(REG_PLL_STAT, 32'h2);
        repeat (LW + 4) @(posedge mclk);
        rd(REG_PLL_STAT, 32'h14);
        wr(REG_PLL_CTRL, 32'h20);
        rd(REG_PLL_STAT, 32'h4);
        pllLockIn <= 1'b1;
        wr(REG_PLL_CTRL, 32'h23);
        repeat (8) @(posedge mclk);
        rd(REG_PLL_STAT, 32'h19);
        wr(REG_PLL_CTRL, 32'h20);
        rd(REG_PLL_STAT, 32'h8);
        wr(REG_PLL_CTRL, 32'h29);
        wr(REG_IMO_CTRL, 32'h303);
        rd(REG_IMO_STAT, 32'h2);
        repeat (IMO_SETTLE_CYC) @(posedge mclk);
        rd(REG_IMO_STAT, 32'h1);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            wr(REG_MST_CTRL, {16'h0, 6'h0, seed[1:0], 6'h0, 2'(k)});
            wr(REG_BUS_DIV, {30'h0, seed[3:2]});
            wr(REG_CPU_DIV, {30'h0, seed[5:4]});
            wr(REG_LSO_CTRL, {30'h0, seed[7:6]});
            rd(REG_LSO_CTRL, {30'h0, seed[7:6]});
            gap(0, ((k < 2) ? 8 : 8 << (k - 1)) * (seed[1:0] + 1));
            gap(1, ((k < 2) ? 8 : 8 << (k - 1)) * (seed[1:0] + 1) * (seed[3:2] + 1));
            gap(2, ((k < 2) ? 8 : 8 << (k - 1)) * (seed[1:0] + 1) * (seed[5:4] + 1));
        end
        repeat (4) @(posedge mclk);
        tally_and_finish();
    end
endmodule
